// file: verilog/t0s_top.sv
/*
 * Timer 0 split mode (two 8-bit timers) and the shared timer control and
 * status register with its overflow and external interrupt flags.
 * Assumes all pins are synchronous to sys_clk, that the mode 0..2 counting
 * logic of both timers sits outside and reports its overflows here, and
 * that the prescaled clock arrives as a one-cycle tick.
 */
`timescale 1ns/1ps
`default_nettype none
module t0s_top
	import t0s_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic countInputZero,
	input wire logic extIrqPinZero,
	input wire logic extIrqPinOne,
	input wire logic prescaleTick,
	input wire logic vecTimer0,
	input wire logic vecTimer1,
	input wire logic vecExt0,
	input wire logic vecExt1,
	input wire logic t0OvfIn,
	input wire logic t1OvfIn,
	output logic irqTimer0,
	output logic irqTimer1,
	output logic irqExt0,
	output logic irqExt1,
	output logic t0CountTick,
	output logic t1RunEnable,
	output logic t1ExtCountBlock,
	output logic t1BaudTick,
	output logic adcTrigger,
	output logic [7:0] modeSelectOut,
	output logic [7:0] clockCtrlOut
);

	// decoded write strobe for one offset
	function automatic logic hit(input logic strobe, input logic [2:0] addr, input logic [2:0] ofs);
		hit = strobe & (addr == ofs);
	endfunction

	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] mode_reg;
	logic [7:0] clk_reg;
	logic [7:0] rdData_reg;
	logic t1Tick_reg;

	logic [7:0] wrMask;
	logic [7:0] wrVal;
	logic [1:0] extSet;
	logic [1:0] extVecClr;
	logic [1:0] extFell;
	logic [1:0] extPin;
	logic [1:0] extVec;
	logic cntFell;

	logic wrCtrl;
	logic wrBit;
	logic wrMode;
	logic wrClk;
	logic wrLow;
	logic wrHigh;

	t0s_mode_t t0Mode;
	t0s_mode_t t1Mode;
	logic split;
	logic runZero;
	logic lowTick;
	logic highTick;
	logic lowInc;
	logic highInc;
	logic [7:0] lowCount;
	logic [7:0] highCount;
	logic lowOvf;
	logic highOvf;
	logic setTf0;
	logic setTf1;

	assign t0Mode = t0s_mode_t'(mode_reg[M_T0_LSB +: 2]);
	assign t1Mode = t0s_mode_t'(mode_reg[M_T1_LSB +: 2]);
	assign split = (t0Mode == T0S_SPLIT);

	// one write strobe per offset
	assign wrCtrl = hit(regWr, regAddr, OFS_CTRL);
	assign wrBit = hit(regWr, regAddr, OFS_BITWR);
	assign wrMode = hit(regWr, regAddr, OFS_MODE);
	assign wrClk = hit(regWr, regAddr, OFS_CLK);
	assign wrLow = hit(regWr, regAddr, OFS_LOW);
	assign wrHigh = hit(regWr, regAddr, OFS_HIGH);

	// software access to the control bits: whole byte or one bit
	always_comb begin
		wrMask = 8'h00;
		wrVal = 8'h00;
		if (wrCtrl) begin
			wrMask = 8'hff;
			wrVal = regWrData;
		end else if (wrBit) begin
			wrMask = 8'h01 << regWrData[2:0];
			wrVal = {8{regWrData[BW_VAL]}};
		end
	end

	// falling edges of the count input
	t0s_fall_detect u_cntEdge (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.en(clkEn),
		.pinLevel(countInputZero),
		.fell(cntFell)
	);

	// timer 0 gating and timebase
	assign runZero = ctrl_reg[B_TR0] & (~mode_reg[M_GATE_ENABLE_ZERO] | extIrqPinZero);

	always_comb begin
		if (mode_reg[M_CT0]) begin
			lowTick = cntFell;
		end else if (clk_reg[C_T0M]) begin
			lowTick = 1'b1;
		end else begin
			lowTick = prescaleTick;
		end
	end

	// upper byte never looks at the count input
	assign highTick = clk_reg[C_T0M] ? 1'b1 : prescaleTick;

	assign lowInc = split & runZero & lowTick;
	assign highInc = split & ctrl_reg[B_TR1] & highTick;
	assign t0CountTick = clkEn & ~split & runZero & lowTick;

	t0s_count8 u_lowByte (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.en(clkEn),
		.load(wrLow),
		.loadData(regWrData),
		.inc(lowInc),
		.count(lowCount),
		.ovf(lowOvf)
	);

	t0s_count8 u_highByte (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.en(clkEn),
		.load(wrHigh),
		.loadData(regWrData),
		.inc(highInc),
		.count(highCount),
		.ovf(highOvf)
	);

	// overflow sources per mode
	assign setTf0 = split ? lowOvf : (clkEn & t0OvfIn);
	assign setTf1 = split ? highOvf : (clkEn & t1OvfIn);

	// both external interrupt channels
	assign extPin = {extIrqPinOne, extIrqPinZero};
	assign extVec = {vecExt1, vecExt0};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ext
			localparam int TYPE = (gi == 0) ? B_IT0 : B_IT1;

			t0s_fall_detect u_pinEdge (
				.sys_clk(sys_clk),
				.arst_n(arst_n),
				.en(clkEn),
				.pinLevel(extPin[gi]),
				.fell(extFell[gi])
			);

			// edge type: falling edge; level type: pin low
			assign extSet[gi] = ctrl_reg[TYPE] ? extFell[gi] : ~extPin[gi];
			assign extVecClr[gi] = extVec[gi] & ctrl_reg[TYPE];
		end
	endgenerate

	// next value of the control register, hardware set wins
	always_comb begin
		ctrl_next = ctrl_reg;
		ctrl_next[B_TR1] = wrMask[B_TR1] ? wrVal[B_TR1] : ctrl_reg[B_TR1];
		ctrl_next[B_TR0] = wrMask[B_TR0] ? wrVal[B_TR0] : ctrl_reg[B_TR0];
		ctrl_next[B_IT1] = wrMask[B_IT1] ? wrVal[B_IT1] : ctrl_reg[B_IT1];
		ctrl_next[B_IT0] = wrMask[B_IT0] ? wrVal[B_IT0] : ctrl_reg[B_IT0];

		// overflow flags: hardware set, then software, then vector
		if (setTf0) begin
			ctrl_next[B_TF0] = 1'b1;
		end else if (wrMask[B_TF0]) begin
			ctrl_next[B_TF0] = wrVal[B_TF0];
		end else if (vecTimer0) begin
			ctrl_next[B_TF0] = 1'b0;
		end

		if (setTf1) begin
			ctrl_next[B_TF1] = 1'b1;
		end else if (wrMask[B_TF1]) begin
			ctrl_next[B_TF1] = wrVal[B_TF1];
		end else if (vecTimer1) begin
			ctrl_next[B_TF1] = 1'b0;
		end

		// level type: flag mirrors the inverted pin, writes ignored
		if (!ctrl_reg[B_IT0]) begin
			ctrl_next[B_IE0] = ~extIrqPinZero;
		end else if (extSet[0]) begin
			ctrl_next[B_IE0] = 1'b1;
		end else if (wrMask[B_IE0]) begin
			ctrl_next[B_IE0] = wrVal[B_IE0];
		end else if (extVecClr[0]) begin
			ctrl_next[B_IE0] = 1'b0;
		end

		// channel one behaves like channel zero
		if (!ctrl_reg[B_IT1]) begin
			ctrl_next[B_IE1] = extSet[1];
		end else if (extSet[1]) begin
			ctrl_next[B_IE1] = 1'b1;
		end else if (wrMask[B_IE1]) begin
			ctrl_next[B_IE1] = wrVal[B_IE1];
		end else if (extVecClr[1]) begin
			ctrl_next[B_IE1] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RST;
		end else if (clkEn) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// mode select register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= MODE_RST;
		end else if (clkEn && wrMode) begin
			mode_reg <= regWrData;
		end
	end

	// clock control register, unused bits stay zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_reg <= CLK_RST;
		end else if (clkEn && wrClk) begin
			clk_reg <= regWrData & CLK_MASK;
		end
	end

	// timer 1 overflow still feeds baud and conversion ticks
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			t1Tick_reg <= 1'b0;
		end else if (clkEn) begin
			t1Tick_reg <= t1OvfIn;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_reg <= 8'h00;
		end else if (clkEn) begin
			if (regRd) begin
				case (regAddr)
					OFS_CTRL: begin
						rdData_reg <= ctrl_reg;
					end
					OFS_MODE: begin
						rdData_reg <= mode_reg;
					end
					OFS_CLK: begin
						rdData_reg <= clk_reg;
					end
					OFS_LOW: begin
						rdData_reg <= lowCount;
					end
					OFS_HIGH: begin
						rdData_reg <= highCount;
					end
					default: begin
						rdData_reg <= 8'h00;
					end
				endcase
			end else begin
				rdData_reg <= 8'h00;
			end
		end
	end

	assign regRdData = rdData_reg;

	// timer 1 run: in split mode its mode alone decides
	assign t1RunEnable = (t1Mode != T0S_SPLIT) & (split | ctrl_reg[B_TR1]);
	assign t1ExtCountBlock = split;
	assign t1BaudTick = t1Tick_reg;
	assign adcTrigger = t1Tick_reg;

	// interrupt requests are the flags themselves
	assign irqTimer0 = ctrl_reg[B_TF0];
	assign irqTimer1 = ctrl_reg[B_TF1];
	assign irqExt0 = ctrl_reg[B_IE0];
	assign irqExt1 = ctrl_reg[B_IE1];
	assign modeSelectOut = mode_reg;
	assign clockCtrlOut = clk_reg;

endmodule
`default_nettype wire

// file: verilog/t0s_pkg.sv
/*
 * Package for the timer 0 split-mode and timer control block: register
 * offsets, bit positions, reset values and the timer mode encoding.
 * Assumes a byte-wide register port with a 3-bit address.
 */
package t0s_pkg;

	// register offsets on the local register port
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_MODE = 3'h1;
	localparam logic [2:0] OFS_CLK = 3'h2;
	localparam logic [2:0] OFS_LOW = 3'h3;
	localparam logic [2:0] OFS_HIGH = 3'h4;
	localparam logic [2:0] OFS_BITWR = 3'h5;

	// timer_control_status bit positions
	localparam int B_TF1 = 7;
	localparam int B_TR1 = 6;
	localparam int B_TF0 = 5;
	localparam int B_TR0 = 4;
	localparam int B_IE1 = 3;
	localparam int B_IT1 = 2;
	localparam int B_IE0 = 1;
	localparam int B_IT0 = 0;

	// timer_mode_select_reg bit positions
	localparam int M_T0_LSB = 0;
	localparam int M_CT0 = 2;
	localparam int M_GATE_ENABLE_ZERO = 3;
	localparam int M_T1_LSB = 4;

	// clock control bit positions and implemented bits
	localparam int C_T0M = 3;
	localparam logic [7:0] CLK_MASK = 8'h1b;

	// single-bit write port fields
	localparam int BW_VAL = 3;

	// values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CLK_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;

	// mode select encoding, in order 0 to 3
	typedef enum logic [1:0] {
		T0S_MODE13,
		T0S_MODE16,
		T0S_MODE8R,
		T0S_SPLIT
	} t0s_mode_t;

endpackage

// file: verilog/t0s_fall_detect.sv
/*
 * Falling-edge detector for a pin already synchronous to sys_clk.
 * Assumes the pin holds each level for at least two clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module t0s_fall_detect
	import t0s_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic en,
	input wire logic pinLevel,
	output logic fell
);

	logic prev_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= 1'b0;
		end else if (en) begin
			prev_reg <= pinLevel;
		end
	end

	// high-to-low seen between two enabled samples
	assign fell = en & prev_reg & ~pinLevel;

endmodule
`default_nettype wire

// file: verilog/t0s_count8.sv
/*
 * One 8-bit count byte: software load, increment, wrap pulse.
 * Assumes load and inc come from the owning block in sys_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module t0s_count8
	import t0s_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic en,
	input wire logic load,
	input wire logic [7:0] loadData,
	input wire logic inc,
	output logic [7:0] count,
	output logic ovf
);

	logic [7:0] count_reg;

	// a software load takes priority over counting
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= COUNT_RST;
		end else if (en) begin
			if (load) begin
				count_reg <= loadData;
			end else if (inc) begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	assign count = count_reg;
	assign ovf = en & inc & ~load & (count_reg == 8'hff);

endmodule
`default_nettype wire

// file: sim/t0s_sva.sv
/*
 * Port checker for t0s_top: overflow flags, vector clears, timer 1 ticks.
 * Assumes it is bound to t0s_top and that clkEn gates every event.
 */
`timescale 1ns/1ps
`default_nettype none
module t0s_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic regWr,
	input wire logic t0OvfIn,
	input wire logic t1OvfIn,
	input wire logic vecTimer0,
	input wire logic vecTimer1,
	input wire logic irqTimer0,
	input wire logic irqTimer1,
	input wire logic t0CountTick,
	input wire logic t1RunEnable,
	input wire logic t1ExtCountBlock,
	input wire logic t1BaudTick,
	input wire logic adcTrigger,
	input wire logic [7:0] modeSelectOut
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic split;
	assign split = modeSelectOut[1:0] == 2'h3;
	property p_ovf0;
		clkEn && !split && t0OvfIn |=> irqTimer0;
	endproperty
	a_ovf0: assert property (p_ovf0) else $error("t0 overflow not flagged");
	property p_ovf1;
		clkEn && !split && t1OvfIn |=> irqTimer1;
	endproperty
	a_ovf1: assert property (p_ovf1) else $error("t1 overflow not flagged");
	property p_vec0;
		clkEn && !split && vecTimer0 && !t0OvfIn && !regWr |=> !irqTimer0;
	endproperty
	a_vec0: assert property (p_vec0) else $error("t0 flag kept after vector");
	property p_vec1;
		clkEn && !split && vecTimer1 && !t1OvfIn && !regWr |=> !irqTimer1;
	endproperty
	a_vec1: assert property (p_vec1) else $error("t1 flag kept after vector");
	property p_tick;
		clkEn && t1OvfIn |=> t1BaudTick && adcTrigger;
	endproperty
	a_tick: assert property (p_tick) else $error("t1 tick missing");
	property p_notick;
		clkEn && !t1OvfIn |=> !t1BaudTick && !adcTrigger;
	endproperty
	a_notick: assert property (p_notick) else $error("t1 tick spurious");
	property p_run1;
		split |-> t1RunEnable == (modeSelectOut[5:4] != 2'h3);
	endproperty
	a_run1: assert property (p_run1) else $error("t1 run wrong in split");
	property p_split;
		split |-> t1ExtCountBlock && !t0CountTick;
	endproperty
	a_split: assert property (p_split) else $error("split outputs wrong");
	c_split: cover property (split && t1OvfIn);
	c_vec0: cover property (vecTimer0 && irqTimer0);
	c_tick: cover property (t1BaudTick);
endmodule
bind t0s_top t0s_chk i_chk (.sys_clk, .arst_n, .clkEn, .regWr, .t0OvfIn, .t1OvfIn, .vecTimer0, .vecTimer1,
	.irqTimer0, .irqTimer1, .t0CountTick, .t1RunEnable, .t1ExtCountBlock, .t1BaudTick, .adcTrigger,
	.modeSelectOut);
`default_nettype wire

// file: sim/t0s_pins.sv
/*
 * Far-side pin model: count input and the two active-low interrupt pins.
 * Assumes the bench holds each requested level at least two cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module t0s_pins (
	input wire logic sys_clk,
	input wire logic [2:0] lvl,
	output logic countInputZero,
	output logic extIrqPinZero,
	output logic extIrqPinOne
);
	// pins idle high, launched just after the edge
	initial {extIrqPinOne, extIrqPinZero, countInputZero} = 3'h7;
	always @(posedge sys_clk) begin
		{extIrqPinOne, extIrqPinZero, countInputZero} <= lvl;
	end
endmodule
`default_nettype wire

// file: sim/test_timer0_split_mode_and_control.sv
/*
 * Bench for t0s_top: register tasks, split counting, flags and pin events.
 * Assumes t0s_pins drives the pins; clkEn is held high except during the final frozen-enable check.
 */
`timescale 1ns/1ps
`default_nettype none
module test_timer0_split_mode_and_control
	import t0s_pkg::*;
;
	logic sys_clk, arst_n, regWr, regRd;
	logic [2:0] regAddr, lvl;
	logic [7:0] regWrData, regRdData, ckOut;
	logic [6:0] pls;
	logic irqTimer0, irqTimer1, irqExt0, irqExt1, t1RunEnable, t1BaudTick, cin, pin0, pin1;
	logic t0Tick, adcTrig, en;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	t0s_pins i_pins (.sys_clk, .lvl, .countInputZero(cin), .extIrqPinZero(pin0), .extIrqPinOne(pin1));
	t0s_top i_dut (.sys_clk, .arst_n, .clkEn(en), .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.countInputZero(cin), .extIrqPinZero(pin0), .extIrqPinOne(pin1), .prescaleTick(pls[0]),
		.vecTimer0(pls[1]), .vecTimer1(pls[2]), .vecExt0(pls[3]), .vecExt1(pls[4]), .t0OvfIn(pls[5]),
		.t1OvfIn(pls[6]), .irqTimer0, .irqTimer1, .irqExt0, .irqExt1, .t0CountTick(t0Tick), .t1RunEnable,
		.t1ExtCountBlock(), .t1BaudTick, .adcTrigger(adcTrig), .modeSelectOut(), .clockCtrlOut(ckOut));
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string w);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic chk1(input logic s, input logic e, input string w);
		chk({7'h0, s}, {7'h0, e}, w);
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(posedge sys_clk);
		chk(regRdData, e, "regRdData");
	endtask
	task automatic bitw(input logic [2:0] b, input logic v);
		wr(OFS_BITWR, {4'h0, v, b});
	endtask
	task automatic pulse(input int i);
		pls[i] <= 1'b1;
		@(posedge sys_clk);
		pls <= '0;
		@(posedge sys_clk);
	endtask
	task automatic pin(input int i, input logic v);
		lvl[i] <= v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic fall(input int i);
		pin(i, 1'b0);
		pin(i, 1'b1);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		{regWr, regRd, regAddr, regWrData, pls} = '0;
		lvl = 3'h7;
		en = 1'b1;
		arst_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		rd(OFS_CTRL, CTRL_RST);
		rd(OFS_MODE, MODE_RST);
		rd(OFS_CLK, CLK_RST);
		rd(3'h6, 8'h00);
		bitw(B_TR0, 1'b1);
		bitw(B_IT1, 1'b1);
		rd(OFS_CTRL, 8'h14);
		bitw(B_TR0, 1'b0);
		rd(OFS_CTRL, 8'h04);
		// split: high byte counts prescale ticks under run_bit_one
		wr(OFS_MODE, 8'h03);
		wr(OFS_HIGH, 8'hfe);
		pulse(0);
		rd(OFS_HIGH, 8'hfe);
		bitw(B_TR1, 1'b1);
		fall(0);
		rd(OFS_HIGH, 8'hfe);
		pulse(0);
		pulse(0);
		rd(OFS_HIGH, 8'h00);
		chk1(irqTimer1, 1'b1, "irqTimer1");
		chk1(t1RunEnable, 1'b1, "t1RunEnable");
		bitw(B_TF1, 1'b0);
		pulse(6);
		chk1(irqTimer1, 1'b0, "irqTimer1");
		chk1(t1BaudTick, 1'b1, "t1BaudTick");
		chk1(adcTrig, 1'b1, "adcTrigger");
		wr(OFS_MODE, 8'h33);
		chk1(t1RunEnable, 1'b0, "t1RunEnable");
		// low byte in counter mode on count-input falls
		wr(OFS_MODE, 8'h07);
		wr(OFS_LOW, 8'hfe);
		bitw(B_TR0, 1'b1);
		fall(0);
		fall(0);
		rd(OFS_LOW, 8'h00);
		chk1(irqTimer0, 1'b1, "irqTimer0");
		bitw(B_TF0, 1'b0);
		chk1(irqTimer0, 1'b0, "irqTimer0");
		wr(OFS_MODE, 8'h0f);
		pin(1, 1'b0);
		fall(0);
		rd(OFS_LOW, 8'h00);
		chk1(irqExt0, 1'b1, "irqExt0");
		pulse(3);
		chk1(irqExt0, 1'b1, "irqExt0");
		pin(1, 1'b1);
		chk1(irqExt0, 1'b0, "irqExt0");
		fall(0);
		rd(OFS_LOW, 8'h01);
		// edge-mode pins cleared by vectoring, then pin one in level mode
		bitw(B_IT0, 1'b1);
		fall(1);
		chk1(irqExt0, 1'b1, "irqExt0");
		pulse(3);
		chk1(irqExt0, 1'b0, "irqExt0");
		fall(2);
		chk1(irqExt1, 1'b1, "irqExt1");
		pulse(4);
		chk1(irqExt1, 1'b0, "irqExt1");
		bitw(B_IT1, 1'b0);
		pin(2, 1'b0);
		chk1(irqExt1, 1'b1, "irqExt1");
		pin(2, 1'b1);
		chk1(irqExt1, 1'b0, "irqExt1");
		// not split: outside overflows set flags, vectors clear
		wr(OFS_MODE, 8'h00);
		pulse(5);
		chk1(irqTimer0, 1'b1, "irqTimer0");
		pulse(1);
		chk1(irqTimer0, 1'b0, "irqTimer0");
		pulse(6);
		chk1(irqTimer1, 1'b1, "irqTimer1");
		pulse(2);
		chk1(irqTimer1, 1'b0, "irqTimer1");
		// internal clock timebase, then timer 0 tick outside split
		wr(OFS_MODE, 8'h03);
		bitw(B_TR0, 1'b0);
		bitw(B_TR1, 1'b0);
		wr(OFS_LOW, 8'h00);
		wr(OFS_CLK, 8'hff);
		rd(OFS_CLK, 8'h1b);
		chk(ckOut, 8'h1b, "clockCtrlOut");
		bitw(B_TR0, 1'b1);
		bitw(B_TR0, 1'b0);
		rd(OFS_LOW, 8'h02);
		wr(OFS_MODE, 8'h00);
		chk1(t0Tick, 1'b0, "t0CountTick");
		bitw(B_TR0, 1'b1);
		chk1(t0Tick, 1'b1, "t0CountTick");
		// frozen clock enable swallows an overflow
		en <= 1'b0;
		pulse(6);
		en <= 1'b1;
		chk1(t1BaudTick, 1'b0, "t1BaudTick");
		chk1(irqTimer1, 1'b0, "irqTimer1");
		tally_and_finish();
	end
endmodule
`default_nettype wire
